// ---- design/btb_map.svh ----
`ifndef BTB_MAP_SVH
`define BTB_MAP_SVH
// timer indices within the six-timer group
`define BTB_N16          6
`define BTB_AUX_IDX      4
`define BTB_IRQ_IDX      5
// mode encodings on the mode ports
`define BTB_MODE_TC      3'h0
`define BTB_MODE_RATE    3'h2
`define BTB_MODE_SQUARE  3'h3
`define BTB_MODE_STROBE  3'h4
// reset values
`define BTB_CNT16_RST    16'h0000
`define BTB_CNT14_RST    14'h0000
`endif

// ---- design/btb_pkg.sv ----
`default_nettype none
package btb_pkg;
   typedef logic [2:0]  btb_mode_t;
   typedef logic [15:0] btb_cnt16_t;
   typedef logic [13:0] btb_cnt14_t;
   // short pulse timer modes
   typedef enum logic { BTB_SP_SINGLE, BTB_SP_REPEAT } btb_sp_mode_t;
endpackage
`default_nettype wire

// ---- design/btb_counter16.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "btb_map.svh"
module btb_counter16 (
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic                ce,
   input  wire logic                tick,
   input  wire logic                load,
   input  wire btb_pkg::btb_cnt16_t load_val,
   input  wire btb_pkg::btb_mode_t  mode,
   input  wire logic                bcd,
   output logic                     out_r,
   output logic                     tc_pulse_r
);
   import btb_pkg::*;

   btb_cnt16_t cnt_r;
   btb_cnt16_t reload_r;
   btb_mode_t  mode_r;
   logic       bcd_r;
   logic       armed_r;
   logic       running_r;
   logic       half_r;

   // decrement in binary or in four bcd digits
   function automatic btb_cnt16_t dec(input btb_cnt16_t v, input logic b);
      btb_cnt16_t r;
      r = v - 16'h0001;
      if (b) begin
         if (v[3:0] == 4'h0) r[3:0] = 4'h9;
         if (v[7:0] == 8'h00) r[7:4] = 4'h9;
         if (v[11:0] == 12'h000) r[11:8] = 4'h9;
         if (v == 16'h0000) r = 16'h9999;
      end
      return r;
   endfunction

   // a loaded zero wraps and acts as the maximum count, except in square mode
   function automatic logic is_one(input btb_cnt16_t v);
      return v == 16'h0001;
   endfunction

   // counter core; square mode counts by two, toggling each half
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_r <= `BTB_CNT16_RST;
         reload_r <= `BTB_CNT16_RST;
         mode_r <= `BTB_MODE_TC;
         bcd_r <= 1'b0;
         armed_r <= 1'b0;
         running_r <= 1'b0;
         half_r <= 1'b0;
         out_r <= 1'b1;
         tc_pulse_r <= 1'b0;
      end else if (ce) begin
         tc_pulse_r <= 1'b0;
         if (load) begin
            reload_r <= load_val;
            cnt_r <= load_val;
            mode_r <= mode;
            bcd_r <= bcd;
            running_r <= 1'b1;
            armed_r <= 1'b1;
            half_r <= 1'b0;
            out_r <= (mode != `BTB_MODE_TC);
         end else if (tick && running_r) begin
            case (mode_r)
               `BTB_MODE_TC: begin
                  cnt_r <= dec(cnt_r, bcd_r);
                  if (is_one(cnt_r) && armed_r) begin
                     out_r <= 1'b1;
                     tc_pulse_r <= 1'b1;
                     armed_r <= 1'b0;
                  end
               end
               `BTB_MODE_RATE: begin
                  // low for one tick, high for n-1
                  if (cnt_r == 16'h0002) begin
                     out_r <= 1'b0;
                     cnt_r <= dec(cnt_r, bcd_r);
                  end else if (is_one(cnt_r)) begin
                     out_r <= 1'b1;
                     tc_pulse_r <= 1'b1;
                     cnt_r <= reload_r;
                  end else begin
                     cnt_r <= dec(cnt_r, bcd_r);
                  end
               end
               `BTB_MODE_SQUARE: begin
                  // odd counts give the extra tick to the high half
                  if (cnt_r <= 16'h0002) begin
                     out_r <= half_r;
                     half_r <= ~half_r;
                     // odd count: low half starts one lower, so the period stays n
                     cnt_r <= (!half_r && reload_r[0]) ? dec(reload_r, bcd_r) : reload_r;
                     if (half_r) tc_pulse_r <= 1'b1;
                  end else begin
                     cnt_r <= dec(dec(cnt_r, bcd_r), bcd_r);
                  end
               end
               `BTB_MODE_STROBE: begin
                  cnt_r <= dec(cnt_r, bcd_r);
                  out_r <= 1'b1;
                  if (is_one(cnt_r) && armed_r) begin
                     out_r <= 1'b0;
                     tc_pulse_r <= 1'b1;
                     armed_r <= 1'b0;
                  end
               end
               default: begin
                  running_r <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ---- design/btb_timer_bank.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "btb_map.svh"
module btb_timer_bank (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire logic                  timer_clk_tick,
   input  wire logic [5:0]            load16,
   input  wire btb_pkg::btb_cnt16_t   load16_val,
   input  wire btb_pkg::btb_mode_t    load16_mode,
   input  wire logic                  load16_bcd,
   input  wire logic                  load14,
   input  wire btb_pkg::btb_cnt14_t   load14_val,
   input  wire btb_pkg::btb_sp_mode_t load14_mode,
   input  wire logic                  aux_cascade_sel,
   input  wire logic [1:0]            aux_channel_sel,
   input  wire logic                  short_irq_en,
   output logic [3:0]                 channel_baud_clk_r,
   output logic [3:0]                 channel_aux_clk_r,
   output logic                       interval_irq_r,
   output logic                       short_pulse_out_r,
   output logic                       short_irq_r
);
   import btb_pkg::*;

   logic [5:0] t_out;
   logic [5:0] t_tc;
   logic [5:0] t_tick;
   logic       aux_out_d_r;
   btb_cnt14_t sp_cnt_r;
   btb_cnt14_t sp_reload_r;
   btb_sp_mode_t sp_mode_r;
   logic       sp_run_r;

   // cascade: the aux output rising edge is one tick to the interval timer
   always_comb begin
      t_tick = {6{timer_clk_tick}};
      if (aux_cascade_sel)
         t_tick[`BTB_IRQ_IDX] = t_out[`BTB_AUX_IDX] && !aux_out_d_r;
   end

   // the six identical 16-bit counters
   genvar gi;
   generate
      for (gi = 0; gi < `BTB_N16; gi++) begin : g_t16
         btb_counter16 u_cnt (
            .ref_clk    (ref_clk),
            .rst        (rst),
            .ce         (ce),
            .tick       (t_tick[gi]),
            .load       (load16[gi]),
            .load_val   (load16_val),
            .mode       (load16_mode),
            .bcd        (load16_bcd),
            .out_r      (t_out[gi]),
            .tc_pulse_r (t_tc[gi])
         );
      end
   endgenerate

   // baud and aux routing, registered so outputs come from flops
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         channel_baud_clk_r <= 4'h0;
         channel_aux_clk_r <= 4'h0;
         aux_out_d_r <= 1'b1; // counter outputs idle high, so no false edge
      end else if (ce) begin
         channel_baud_clk_r <= t_out[3:0];
         aux_out_d_r <= t_out[`BTB_AUX_IDX];
         channel_aux_clk_r <= 4'h0;
         // rate and strobe on the aux timer are only meant for cascade use
         if (!aux_cascade_sel)
            channel_aux_clk_r[aux_channel_sel] <= t_out[`BTB_AUX_IDX];
      end
   end

   // interval interrupt: one-cycle request at each terminal count
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         interval_irq_r <= 1'b0;
      end else if (ce) begin
         interval_irq_r <= t_tc[`BTB_IRQ_IDX];
      end
   end

   // 14-bit pulse timer, low for one tick at terminal count
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sp_cnt_r <= `BTB_CNT14_RST;
         sp_reload_r <= `BTB_CNT14_RST;
         sp_mode_r <= BTB_SP_SINGLE;
         sp_run_r <= 1'b0;
         short_pulse_out_r <= 1'b1;
         short_irq_r <= 1'b0;
      end else if (ce) begin
         short_irq_r <= 1'b0;
         if (load14) begin
            sp_cnt_r <= load14_val;
            sp_reload_r <= load14_val;
            sp_mode_r <= load14_mode;
            sp_run_r <= 1'b1;
            short_pulse_out_r <= 1'b1;
         end else if (timer_clk_tick) begin
            short_pulse_out_r <= 1'b1;
            if (sp_run_r) begin
               if (sp_cnt_r == 14'h0001) begin
                  short_pulse_out_r <= 1'b0;
                  short_irq_r <= short_irq_en;
                  sp_cnt_r <= sp_reload_r;
                  if (sp_mode_r == BTB_SP_SINGLE) sp_run_r <= 1'b0;
               end else begin
                  sp_cnt_r <= sp_cnt_r - 14'h0001;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- bench/btb_baud_rx.sv ----
`timescale 1ns/1ns
`default_nettype none
// serial channel side: times each baud clock period it receives
module btb_baud_rx (
   input  wire logic ref_clk,
   input  wire logic baud_clk,
   output var  int   period,
   output var  int   high_len
);
   int   cnt = 0;
   int   hcnt = 0;
   logic prev = 1'b0;
   // a rising edge closes a period; only listens, never drives the board
   always @(posedge ref_clk) begin
      if (baud_clk && !prev) begin
         period <= cnt;
         high_len <= hcnt;
         cnt <= 1;
         hcnt <= 1;
      end else begin
         cnt <= cnt + 1;
         hcnt <= hcnt + (baud_clk ? 1 : 0);
      end
      prev <= baud_clk;
   end
endmodule
`default_nettype wire

// ---- bench/btb_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module btb_chk (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       ce,
   input wire logic       timer_clk_tick,
   input wire logic       aux_cascade_sel,
   input wire logic [1:0] aux_channel_sel,
   input wire logic       short_irq_en,
   input wire logic [3:0] channel_baud_clk_r,
   input wire logic [3:0] channel_aux_clk_r,
   input wire logic       interval_irq_r,
   input wire logic       short_pulse_out_r,
   input wire logic       short_irq_r
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // select may be one or two stages behind the output register
   a_reset_idle: assert property ($past(rst) |-> channel_baud_clk_r == 4'h0
      && !interval_irq_r && short_pulse_out_r) else $error("outputs not idle after reset");
   a_cascade_quiet: assert property ($past(aux_cascade_sel)
      && $past(aux_cascade_sel, 2) |-> channel_aux_clk_r == 4'h0)
      else $error("aux clock seen while cascaded");
   a_aux_only_sel: assert property ((channel_aux_clk_r
      & ~(4'h1 << $past(aux_channel_sel)) & ~(4'h1 << $past(aux_channel_sel, 2))) == 4'h0)
      else $error("aux on wrong channel");
   a_irq_one_cycle: assert property (interval_irq_r && ce |=> !interval_irq_r)
      else $error("interval irq longer than one cycle");
   a_short_irq_gate: assert property (short_irq_r
      |-> $past(short_irq_en) || $past(short_irq_en, 2))
      else $error("short irq without enable");
   // low lasts one input clock, so a tick or a load14 at the next edge ends it
   a_short_low_one: assert property ($fell(short_pulse_out_r) && ce && timer_clk_tick
      |=> short_pulse_out_r) else $error("short pulse low too long");
   a_baud_freeze: assert property (!ce |=> $stable(channel_baud_clk_r))
      else $error("baud clock moved while frozen");
   a_short_freeze: assert property (!ce |=> $stable(short_pulse_out_r))
      else $error("short pulse moved while frozen");
   c_cascade_irq: cover property (aux_cascade_sel && interval_irq_r);
   c_short_irq: cover property (short_irq_r);
   c_aux_clk: cover property (|channel_aux_clk_r);
endmodule
bind btb_timer_bank btb_chk chk_u (.ref_clk, .rst, .ce, .timer_clk_tick, .aux_cascade_sel,
   .aux_channel_sel, .short_irq_en, .channel_baud_clk_r, .channel_aux_clk_r, .interval_irq_r,
   .short_pulse_out_r, .short_irq_r);
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
   import btb_pkg::*;
   logic         ref_clk = 1'b0;
   logic         rst = 1'b1;
   logic         ce = 1'b1;
   logic         timer_clk_tick = 1'b1;
   logic [5:0]   load16 = 6'h00;
   btb_cnt16_t   load16_val = 16'h0000;
   btb_mode_t    load16_mode = 3'h0;
   logic         load16_bcd = 1'b0;
   logic         load14 = 1'b0;
   btb_cnt14_t   load14_val = 14'h0000;
   btb_sp_mode_t load14_mode = BTB_SP_SINGLE;
   logic         aux_cascade_sel = 1'b0;
   logic [1:0]   aux_channel_sel = 2'h2;
   logic         short_irq_en = 1'b0;
   logic [3:0]   channel_baud_clk_r;
   logic [3:0]   channel_aux_clk_r;
   logic         interval_irq_r;
   logic         short_pulse_out_r;
   logic         short_irq_r;
   int           per[5];
   int           hi[5];
   int           ep[5];
   int           t;
   int           lo;
   int           fl;
   logic [4:0]   rx_clk;
   int           mismatches = 0;
   int           samples_checked = 0;
   logic [31:0]  seed = 32'h25;
   btb_timer_bank dut_u (.ref_clk, .rst, .ce, .timer_clk_tick, .load16, .load16_val,
      .load16_mode, .load16_bcd, .load14, .load14_val, .load14_mode, .aux_cascade_sel,
      .aux_channel_sel, .short_irq_en, .channel_baud_clk_r, .channel_aux_clk_r,
      .interval_irq_r, .short_pulse_out_r, .short_irq_r);
   // channel receivers, plus one on the routed aux clock
   assign rx_clk = {channel_aux_clk_r[2], channel_baud_clk_r};
   for (genvar g = 0; g < 5; g++) begin : rx_g
      btb_baud_rx rx_u (.ref_clk, .baud_clk(rx_clk[g]), .period(per[g]), .high_len(hi[g]));
   end
   always #50 ref_clk = ~ref_clk;
   function automatic int xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return int'(seed[7:0]);
   endfunction
   task automatic chk(input int got, input int exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic ld16(input int i, input int v, input btb_mode_t m, input logic b);
      @(negedge ref_clk);
      load16 = 6'h01 << i;
      load16_val = v[15:0];
      load16_mode = m;
      load16_bcd = b;
      @(negedge ref_clk);
      load16 = 6'h00;
   endtask
   task automatic ld14(input int v, input btb_sp_mode_t m);
      @(negedge ref_clk);
      load14 = 1'b1;
      load14_val = v[13:0];
      load14_mode = m;
      @(negedge ref_clk);
      load14 = 1'b0;
   endtask
   // bounded wait for the next interval (0) or short (1) irq pulse
   task automatic wp(input logic s, output int c);
      c = 0;
      while ((s ? short_irq_r : interval_irq_r) !== 1'b1 && c < 400) begin
         @(negedge ref_clk);
         c++;
      end
   endtask
   // counts short irq pulses and low cycles of the short pulse pin
   task automatic cnt(input int len, output int c, output int l);
      c = 0;
      l = 0;
      repeat (len) begin
         @(negedge ref_clk);
         c += int'(short_irq_r === 1'b1);
         l += int'(short_pulse_out_r === 1'b0);
      end
   endtask
   task automatic results;
      if (mismatches == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // main sequence: baud periods, interval timing, short timer modes
   initial begin
      repeat (16) @(negedge ref_clk);
      rst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         ep[i] = 4 + 2 * (xs() % 20);
         ld16(i, ep[i], 3'h3, 1'b0);
      end
      ld16(4, 16'h0010, 3'h3, 1'b1);
      ep[4] = 10;
      ld16(1, 6, 3'h2, 1'b0);
      ep[1] = 6;
      repeat (150) @(negedge ref_clk);
      for (int i = 0; i < 5; i++) begin
         chk(per[i], ep[i]);
         chk(hi[i], i == 1 ? ep[1] - 1 : ep[i] / 2);
      end
      ce = 1'b0;
      repeat (20) @(negedge ref_clk);
      ce = 1'b1;
      ld16(5, 7, 3'h0, 1'b0);
      wp(1'b0, t);
      chk(int'(t >= 6 && t <= 10), 1);
      aux_cascade_sel = 1'b1;
      ld16(4, 5, 3'h2, 1'b0);
      ld16(5, 3, 3'h0, 1'b0);
      wp(1'b0, t);
      chk(int'(t >= 9 && t <= 20), 1);
      short_irq_en = 1'b1;
      ld14(6, BTB_SP_REPEAT);
      wp(1'b1, t);
      @(negedge ref_clk);
      wp(1'b1, t);
      chk(t + 1, 6);
      ld14(6, BTB_SP_SINGLE);
      cnt(60, t, lo);
      chk(t, 1);
      chk(lo, 1);
      short_irq_en = 1'b0;
      ld14(6, BTB_SP_REPEAT);
      cnt(40, t, lo);
      chk(t, 0);
      chk(lo, 40 / 6);
      // strobe on timer 0 with the input clock at half the reference rate
      ld16(0, 5, 3'h4, 1'b0);
      timer_clk_tick = 1'b0;
      t = 0;
      lo = 0;
      fl = 0;
      repeat (30) begin
         @(negedge ref_clk);
         t++;
         timer_clk_tick = ~timer_clk_tick;
         if (channel_baud_clk_r[0] === 1'b0) begin
            lo++;
            if (fl == 0)
               fl = t;
         end
      end
      chk(fl, 2 * 5 + 1);
      chk(lo, 2);
      timer_clk_tick = 1'b1;
      results();
   end
   // hang guard, well beyond the roughly 380 cycles above
   initial begin
      repeat (5000) @(posedge ref_clk);
      mismatches++;
      results();
   end
endmodule
`default_nettype wire
